// ===== src/oag_top.sv
// Operand address generator: forms operand value, data address or jump target
`timescale 1ns/100ps
module oag_top (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic req_i,
	input wire oag_pkg::oag_mode_e mode_i,
	input wire logic [7:0] op_lo_i,
	input wire logic [7:0] op_hi_i,
	input wire logic [7:0] acc_i,
	input wire logic [7:0] x_i,
	input wire logic [7:0] y_i,
	input wire logic carry_i,
	input wire logic [7:0] psw_i,
	input wire logic page_sel_i,
	input wire logic [7:0] ram_page_i,
	input wire logic mem_rvalid_i,
	input wire logic [7:0] mem_rdata_i,
	output logic busy_o,
	output logic done_o,
	output logic [15:0] addr_o,
	output logic [7:0] val_o,
	output logic mem_o,
	output logic prog_o,
	output logic mem_rd_o,
	output logic [15:0] mem_raddr_o,
	output logic x_wr_o,
	output logic [7:0] x_next_o
);

	typedef struct packed {
		oag_pkg::oag_state_e st;
		oag_pkg::oag_mode_e mode;
		logic gsel;
		logic [7:0] page;
		logic [7:0] yi;
		logic [7:0] plo;
		logic [15:0] addr;
		logic [15:0] raddr;
		logic [7:0] val;
		logic busy;
		logic done;
		logic mem;
		logic prog;
		logic rd;
		logic xwr;
		logic [7:0] xnx;
	} oag_regs_s;

	oag_regs_s s_ff;
	oag_regs_s nxt_s;

	// Direct-page address: page register on top only when the page flag is set
	function automatic logic [15:0] dpa(input logic g, input logic [7:0] pg, input logic [7:0] off);
		dpa = g ? {pg, off} : {oag_pkg::ZERO8, off};
	endfunction

	// Next-state logic; requests are taken only in idle, so pointer fetches hold them off
	always_comb begin
		nxt_s = s_ff;
		nxt_s.done = 1'b0;
		nxt_s.rd = 1'b0;
		nxt_s.xwr = 1'b0;
		case (s_ff.st)
			oag_pkg::S_IDLE: begin
				if (req_i) begin
					nxt_s.mode = mode_i;
					nxt_s.gsel = page_sel_i;
					nxt_s.page = ram_page_i;
					nxt_s.yi = y_i;
					nxt_s.mem = 1'b1;
					nxt_s.prog = 1'b0;
					nxt_s.val = oag_pkg::ZERO8;
					nxt_s.done = 1'b1;
					case (mode_i)
						oag_pkg::M_REG_A: begin
							nxt_s.mem = 1'b0;
							nxt_s.val = acc_i;
						end
						oag_pkg::M_REG_X: begin
							nxt_s.mem = 1'b0;
							nxt_s.val = x_i;
						end
						oag_pkg::M_REG_Y: begin
							nxt_s.mem = 1'b0;
							nxt_s.val = y_i;
						end
						oag_pkg::M_REG_C: begin
							nxt_s.mem = 1'b0;
							nxt_s.val = 8'(carry_i);
						end
						oag_pkg::M_REG_PSW: begin
							nxt_s.mem = 1'b0;
							nxt_s.val = psw_i;
						end
						oag_pkg::M_IMM: begin
							nxt_s.mem = 1'b0;
							nxt_s.val = op_lo_i;
						end
						oag_pkg::M_DP: nxt_s.addr = dpa(page_sel_i, ram_page_i, op_lo_i);
						// Absolute never looks at the page flag, so the address is the full 16-bit operand
						oag_pkg::M_ABS: nxt_s.addr = {op_hi_i, op_lo_i};
						oag_pkg::M_DPX0: nxt_s.addr = dpa(page_sel_i, ram_page_i, x_i);
						oag_pkg::M_DPX: nxt_s.addr = dpa(page_sel_i, ram_page_i, 8'(op_lo_i + x_i));
						oag_pkg::M_DPXINC: begin
							nxt_s.addr = dpa(page_sel_i, ram_page_i, x_i);
							nxt_s.xwr = 1'b1;
							nxt_s.xnx = 8'(x_i + oag_pkg::ONE8);
						end
						oag_pkg::M_DPY: nxt_s.addr = dpa(page_sel_i, ram_page_i, 8'(op_lo_i + y_i));
						oag_pkg::M_ABSY: nxt_s.addr = 16'({op_hi_i, op_lo_i} + {oag_pkg::ZERO8, y_i});
						oag_pkg::M_DPIND, oag_pkg::M_DPYIND: begin
							nxt_s.done = 1'b0;
							nxt_s.busy = 1'b1;
							nxt_s.rd = 1'b1;
							nxt_s.raddr = dpa(page_sel_i, ram_page_i, op_lo_i);
							nxt_s.st = oag_pkg::S_PTR_LO;
						end
						oag_pkg::M_DPXIND: begin
							nxt_s.done = 1'b0;
							nxt_s.busy = 1'b1;
							nxt_s.rd = 1'b1;
							nxt_s.raddr = dpa(page_sel_i, ram_page_i, 8'(op_lo_i + x_i));
							nxt_s.st = oag_pkg::S_PTR_LO;
						end
						oag_pkg::M_ABSIND: begin
							nxt_s.done = 1'b0;
							nxt_s.busy = 1'b1;
							nxt_s.rd = 1'b1;
							nxt_s.raddr = {op_hi_i, op_lo_i};
							nxt_s.st = oag_pkg::S_PTR_LO;
						end
						// Unknown code: the previous result stays as it was and nothing is raised
						default: begin
							nxt_s.mode = s_ff.mode;
							nxt_s.gsel = s_ff.gsel;
							nxt_s.page = s_ff.page;
							nxt_s.yi = s_ff.yi;
							nxt_s.mem = s_ff.mem;
							nxt_s.prog = s_ff.prog;
							nxt_s.val = s_ff.val;
							nxt_s.done = 1'b0;
						end
					endcase
				end
			end
			oag_pkg::S_PTR_LO: begin
				// Low pointer byte arrived; fetch the high byte from the next location
				if (mem_rvalid_i) begin
					nxt_s.plo = mem_rdata_i;
					nxt_s.rd = 1'b1;
					nxt_s.st = oag_pkg::S_PTR_HI;
					if (s_ff.mode == oag_pkg::M_ABSIND) begin
						nxt_s.raddr = 16'(s_ff.raddr + oag_pkg::ONE16);
					end else begin
						// Pair stays inside the direct page
						nxt_s.raddr = dpa(s_ff.gsel, s_ff.page, 8'(s_ff.raddr[7:0] + oag_pkg::ONE8));
					end
				end
			end
			oag_pkg::S_PTR_HI: begin
				if (mem_rvalid_i) begin
					nxt_s.st = oag_pkg::S_IDLE;
					nxt_s.busy = 1'b0;
					nxt_s.done = 1'b1;
					nxt_s.mem = 1'b1;
					nxt_s.prog = (s_ff.mode == oag_pkg::M_DPIND) || (s_ff.mode == oag_pkg::M_ABSIND);
					if (s_ff.mode == oag_pkg::M_DPYIND) begin
						nxt_s.addr = 16'({mem_rdata_i, s_ff.plo} + {oag_pkg::ZERO8, s_ff.yi});
					end else begin
						nxt_s.addr = {mem_rdata_i, s_ff.plo};
					end
				end
			end
			default: nxt_s.st = oag_pkg::S_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Every output is a field of the state register
	assign busy_o = s_ff.busy;
	assign done_o = s_ff.done;
	assign addr_o = s_ff.addr;
	assign val_o = s_ff.val;
	assign mem_o = s_ff.mem;
	assign prog_o = s_ff.prog;
	assign mem_rd_o = s_ff.rd;
	assign mem_raddr_o = s_ff.raddr;
	assign x_wr_o = s_ff.xwr;
	assign x_next_o = s_ff.xnx;

	// Checks on the produced addresses and values
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	// A request counts only while idle; one that arrives during a fetch is dropped
	logic idle_req;
	assign idle_req = req_i && !busy_o;

	// Register and immediate operands never touch memory
	chk_reg_value: assert property (idle_req && mode_i == oag_pkg::M_REG_X
		|=> done_o && !mem_o && val_o == $past(x_i))
		else $error("register operand wrong");
	chk_reg_acc: assert property (idle_req && mode_i == oag_pkg::M_REG_A
		|=> done_o && !mem_o && val_o == $past(acc_i))
		else $error("accumulator operand wrong");
	chk_reg_carry: assert property (idle_req && mode_i == oag_pkg::M_REG_C
		|=> done_o && !mem_o && val_o == 8'($past(carry_i)))
		else $error("carry operand wrong");
	chk_imm_value: assert property (idle_req && mode_i == oag_pkg::M_IMM
		|=> done_o && !mem_o && !mem_rd_o && val_o == $past(op_lo_i))
		else $error("immediate operand wrong");
	// Direct page and absolute addresses
	chk_dp_paged: assert property (idle_req && mode_i == oag_pkg::M_DP && page_sel_i
		|=> addr_o == {$past(ram_page_i), $past(op_lo_i)})
		else $error("paged direct address wrong");
	chk_dp_zero: assert property (idle_req && mode_i == oag_pkg::M_DP && !page_sel_i
		|=> addr_o[15:8] == oag_pkg::ZERO8 && addr_o[7:0] == $past(op_lo_i))
		else $error("page zero address wrong");
	chk_dp_flags: assert property (idle_req && mode_i == oag_pkg::M_DP
		|=> done_o && mem_o && !prog_o && !mem_rd_o && val_o == oag_pkg::ZERO8)
		else $error("direct operand flags wrong");
	chk_abs_addr: assert property (idle_req && mode_i == oag_pkg::M_ABS
		|=> mem_o && addr_o == {$past(op_hi_i), $past(op_lo_i)})
		else $error("absolute address wrong");
	chk_abs_nopage: assert property (idle_req && mode_i == oag_pkg::M_ABS && page_sel_i
		|=> addr_o == {$past(op_hi_i), $past(op_lo_i)})
		else $error("absolute address follows page flag");
	// Indexed addresses; direct-page offset sums stay inside the page, the absolute Y sum carries into the high byte
	chk_dpx_zero: assert property (idle_req && mode_i == oag_pkg::M_DPX0 && !page_sel_i
		|=> addr_o == {oag_pkg::ZERO8, $past(x_i)})
		else $error("X direct address wrong");
	chk_dpx_paged: assert property (idle_req && mode_i == oag_pkg::M_DPX0 && page_sel_i
		|=> addr_o == {$past(ram_page_i), $past(x_i)})
		else $error("paged X direct address wrong");
	chk_dpx_wrap: assert property (idle_req && mode_i == oag_pkg::M_DPX && !page_sel_i
		|=> addr_o == {oag_pkg::ZERO8, 8'($past(op_lo_i) + $past(x_i))})
		else $error("X offset address wrong");
	chk_xinc_step: assert property (idle_req && mode_i == oag_pkg::M_DPXINC
		|=> x_wr_o && done_o && x_next_o == 8'($past(x_i) + oag_pkg::ONE8))
		else $error("X increment wrong");
	chk_dpy_wrap: assert property (idle_req && mode_i == oag_pkg::M_DPY && page_sel_i
		|=> addr_o == {$past(ram_page_i), 8'($past(op_lo_i) + $past(y_i))})
		else $error("Y offset address wrong");
	chk_dpy_zero: assert property (idle_req && mode_i == oag_pkg::M_DPY && !page_sel_i
		|=> addr_o == {oag_pkg::ZERO8, 8'($past(op_lo_i) + $past(y_i))})
		else $error("page zero Y offset address wrong");
	chk_absy_sum: assert property (idle_req && mode_i == oag_pkg::M_ABSY
		|=> addr_o == 16'({$past(op_hi_i), $past(op_lo_i)} + {oag_pkg::ZERO8, $past(y_i)}))
		else $error("Y absolute address wrong");
	// Pointer fetches: first read address, second read address, final target
	chk_dpind_start: assert property (idle_req && mode_i == oag_pkg::M_DPIND && !page_sel_i
		|=> mem_rd_o && busy_o && !done_o && mem_raddr_o == {oag_pkg::ZERO8, $past(op_lo_i)})
		else $error("direct pointer address wrong");
	chk_ind_start: assert property (idle_req && mode_i == oag_pkg::M_DPXIND && !page_sel_i
		|=> mem_rd_o && busy_o && !done_o && mem_raddr_o == {oag_pkg::ZERO8, 8'($past(op_lo_i) + $past(x_i))})
		else $error("indexed pointer address wrong");
	chk_ptr_lo_addr: assert property (idle_req && mode_i == oag_pkg::M_DPYIND && page_sel_i
		|=> mem_rd_o && busy_o && mem_raddr_o == {$past(ram_page_i), $past(op_lo_i)})
		else $error("paged pointer address wrong");
	chk_absind_start: assert property (idle_req && mode_i == oag_pkg::M_ABSIND
		|=> mem_rd_o && busy_o && mem_raddr_o == {$past(op_hi_i), $past(op_lo_i)})
		else $error("absolute pointer address wrong");
	chk_dp_next_wrap: assert property (s_ff.st == oag_pkg::S_PTR_LO && mem_rvalid_i
		&& s_ff.mode != oag_pkg::M_ABSIND
		|=> mem_rd_o && mem_raddr_o == {$past(s_ff.raddr[15:8]), 8'($past(s_ff.raddr[7:0]) + oag_pkg::ONE8)})
		else $error("pointer high byte left the page");
	chk_absind_next: assert property (s_ff.st == oag_pkg::S_PTR_LO && mem_rvalid_i
		&& s_ff.mode == oag_pkg::M_ABSIND
		|=> mem_rd_o && mem_raddr_o == 16'($past(s_ff.raddr) + oag_pkg::ONE16))
		else $error("absolute pointer high address wrong");
	chk_ptr_pair: assert property (s_ff.st == oag_pkg::S_PTR_HI && mem_rvalid_i
		&& s_ff.mode != oag_pkg::M_DPYIND
		|=> done_o && addr_o == {$past(mem_rdata_i), $past(s_ff.plo)})
		else $error("pointer target wrong");
	chk_ptr_yadd: assert property (s_ff.st == oag_pkg::S_PTR_HI && mem_rvalid_i
		&& s_ff.mode == oag_pkg::M_DPYIND
		|=> !prog_o && addr_o == 16'({$past(mem_rdata_i), $past(s_ff.plo)} + {oag_pkg::ZERO8, $past(s_ff.yi)}))
		else $error("Y indirect address wrong");
	chk_jump_flag: assert property (s_ff.st == oag_pkg::S_PTR_HI && mem_rvalid_i
		&& (s_ff.mode == oag_pkg::M_DPIND || s_ff.mode == oag_pkg::M_ABSIND)
		|=> done_o && prog_o && mem_o && !busy_o)
		else $error("jump target not flagged");

endmodule

// ===== src/oag_pkg.sv
// Shared types and constants of the operand address generator
package oag_pkg;
	localparam int DW = 8;
	localparam int AW = 16;
	localparam logic [7:0] ZERO8 = 8'h00;
	localparam logic [7:0] ONE8 = 8'h01;
	localparam logic [15:0] ONE16 = 16'h0001;

	// Operand addressing modes requested by the instruction decoder
	typedef enum logic [4:0] {
		M_REG_A, M_REG_X, M_REG_Y, M_REG_C, M_REG_PSW,
		M_IMM, M_DP, M_ABS,
		M_DPX0, M_DPX, M_DPXINC, M_DPY, M_ABSY,
		M_DPIND, M_DPXIND, M_DPYIND, M_ABSIND
	} oag_mode_e;

	// Sequencer states: pointer fetch needs two memory reads
	typedef enum logic [1:0] {
		S_IDLE, S_PTR_LO, S_PTR_HI
	} oag_state_e;
endpackage

// ===== bench/oag_mem_model.sv
// Memory model answering pointer byte reads of the address generator
`timescale 1ns/100ps
module oag_mem_model (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic slow_i,
	input wire logic rd_i,
	input wire logic [15:0] raddr_i,
	output logic rvalid_o,
	output logic [7:0] rdata_o
);
	logic [15:0] addr_ff;
	logic [2:0] wait_ff;
	logic pend_ff;
	// Content is a fixed mix of the address; idle data toggles so stale bytes never look valid
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pend_ff <= 1'h0;
			addr_ff <= 16'h0000;
			wait_ff <= 3'h0;
			rvalid_o <= 1'h0;
			rdata_o <= 8'hFF;
		end else begin
			rvalid_o <= 1'h0;
			rdata_o <= ~rdata_o;
			if (rd_i) begin
				pend_ff <= 1'h1;
				addr_ff <= raddr_i;
				wait_ff <= slow_i ? 3'h3 : 3'h0; // Slow answers stall three extra cycles
			end else if (pend_ff && wait_ff != 3'h0) begin
				wait_ff <= wait_ff - 3'h1;
			end else if (pend_ff) begin
				pend_ff <= 1'h0;
				rvalid_o <= 1'h1;
				rdata_o <= addr_ff[7:0] + addr_ff[15:8] + 8'h11;
			end
		end
	end
endmodule

// ===== bench/test_oag_top.sv
// Self-checking testbench of the operand address generator
`timescale 1ns/100ps
module test_oag_top;
	logic clk_i = 1'h0;
	logic reset_n_i = 1'h0;
	logic req = 1'h0, c = 1'h1, pg = 1'h0, slow = 1'h0, busy_o, done_o, mem_o, prog_o, mem_rd_o, x_wr_o, rv;
	logic [7:0] lo = 8'h00, hi = 8'h00, a = 8'h3C, x = 8'hF5, y = 8'h55, program_status_word = 8'h82, rp = 8'h05;
	logic [7:0] val_o, x_next_o, rd;
	logic [15:0] addr_o, mem_raddr_o;
	oag_pkg::oag_mode_e mode = oag_pkg::M_REG_A;
	int fail_count = 0, n_checks = 0, cyc = 0;
	oag_top uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .req_i(req), .mode_i(mode), .op_lo_i(lo), .op_hi_i(hi),
		.acc_i(a), .x_i(x), .y_i(y), .carry_i(c), .psw_i(program_status_word), .page_sel_i(pg), .ram_page_i(rp),
		.mem_rvalid_i(rv), .mem_rdata_i(rd), .busy_o(busy_o), .done_o(done_o), .addr_o(addr_o), .val_o(val_o),
		.mem_o(mem_o), .prog_o(prog_o), .mem_rd_o(mem_rd_o), .mem_raddr_o(mem_raddr_o), .x_wr_o(x_wr_o),
		.x_next_o(x_next_o));
	oag_mem_model mem (.clk_i(clk_i), .reset_n_i(reset_n_i), .slow_i(slow), .rd_i(mem_rd_o),
		.raddr_i(mem_raddr_o), .rvalid_o(rv), .rdata_o(rd));
	always #4 clk_i = ~clk_i;
	// Hang guard: the whole run needs about 110 cycles
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			fail_count++;
			stop_test();
		end
	end
	function automatic logic [15:0] dpa(input logic [7:0] b);
		dpa = {pg ? rp : 8'h00, b};
	endfunction
	function automatic logic [7:0] mb(input logic [15:0] ad);
		mb = ad[7:0] + ad[15:8] + 8'h11;
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One request, wait for the result, then compare; f is {prog, mem}
	task automatic run(input oag_pkg::oag_mode_e m, input logic [7:0] l, input logic [7:0] h,
		input logic [15:0] ea, input logic [7:0] ev, input logic [1:0] f);
		int k;
		logic ind;
		ind = (m == oag_pkg::M_DPIND) || (m == oag_pkg::M_DPXIND) || (m == oag_pkg::M_DPYIND) || (m == oag_pkg::M_ABSIND);
		mode = m;
		lo = l;
		hi = h;
		req = 1'h1;
		@(negedge clk_i);
		req = 1'h0;
		chk(16'({busy_o, mem_rd_o}), ind ? 16'h0003 : 16'h0000);
		for (k = 0; k < 20 && done_o !== 1'h1; k++) @(negedge clk_i);
		chk(16'(busy_o), 16'h0000);
		chk(16'(done_o), 16'h0001);
		chk(16'(x_wr_o), 16'(m == oag_pkg::M_DPXINC));
		chk(16'(val_o), 16'(ev));
		chk(16'({prog_o, mem_o}), 16'(f));
		if (f[0]) chk(addr_o, ea);
	endtask
	task automatic t_direct();
		run(oag_pkg::M_REG_A, 8'h00, 8'h00, 16'h0000, 8'h3C, 2'h0);
		run(oag_pkg::M_REG_X, 8'h00, 8'h00, 16'h0000, 8'hF5, 2'h0);
		run(oag_pkg::M_REG_Y, 8'h00, 8'h00, 16'h0000, 8'h55, 2'h0);
		run(oag_pkg::M_REG_C, 8'h00, 8'h00, 16'h0000, 8'h01, 2'h0);
		run(oag_pkg::M_REG_PSW, 8'h00, 8'h00, 16'h0000, 8'h82, 2'h0);
		run(oag_pkg::M_IMM, 8'h35, 8'h00, 16'h0000, 8'h35, 2'h0);
		run(oag_pkg::M_DP, 8'h35, 8'h00, 16'h0035, 8'h00, 2'h1);
		pg = 1'h1;
		run(oag_pkg::M_DP, 8'h35, 8'h00, 16'h0535, 8'h00, 2'h1);
		run(oag_pkg::M_ABS, 8'h35, 8'h01, 16'h0135, 8'h00, 2'h1);
		pg = 1'h0;
		run(oag_pkg::M_ABS, 8'h35, 8'hF0, 16'hF035, 8'h00, 2'h1);
		$display("direct modes done");
	endtask
	task automatic t_index();
		run(oag_pkg::M_DPX0, 8'h00, 8'h00, 16'h00F5, 8'h00, 2'h1);
		run(oag_pkg::M_DPX, 8'h45, 8'h00, 16'h003A, 8'h00, 2'h1);
		run(oag_pkg::M_DPXINC, 8'h00, 8'h00, 16'h00F5, 8'h00, 2'h1);
		chk(16'(x_next_o), 16'h00F6);
		run(oag_pkg::M_DPY, 8'hF8, 8'h00, 16'h004D, 8'h00, 2'h1);
		run(oag_pkg::M_ABSY, 8'h00, 8'hFA, 16'hFA55, 8'h00, 2'h1);
		pg = 1'h1;
		run(oag_pkg::M_DPX0, 8'h00, 8'h00, 16'h05F5, 8'h00, 2'h1);
		run(oag_pkg::M_DPY, 8'hF8, 8'h00, 16'h054D, 8'h00, 2'h1);
		pg = 1'h0;
		$display("indexed modes done");
	endtask
	// Reset in the middle of a pointer fetch clears every output; a request right after release is taken
	task automatic t_reset();
		pg = 1'h0;
		mode = oag_pkg::M_DPIND;
		lo = 8'h35;
		req = 1'h1;
		@(negedge clk_i);
		req = 1'h0;
		chk(16'(busy_o), 16'h0001);
		reset_n_i = 1'h0;
		repeat (2) @(negedge clk_i);
		chk({busy_o, done_o, mem_rd_o, prog_o, mem_o, x_wr_o, 2'h0, val_o}, 16'h0000);
		chk(addr_o, 16'h0000);
		chk(mem_raddr_o, 16'h0000);
		chk({x_next_o, 8'h00}, 16'h0000);
		reset_n_i = 1'h1;
		run(oag_pkg::M_DP, 8'h35, 8'h00, 16'h0035, 8'h00, 2'h1);
		$display("reset test done");
	endtask
	// Fast then slow memory; the slow pass also uses a paged direct page
	task automatic t_indirect();
		for (int s = 0; s < 2; s++) begin
			slow = s[0];
			pg = s[0];
			x = 8'h10;
			run(oag_pkg::M_DPIND, 8'h35, 8'h00, {mb(dpa(8'h36)), mb(dpa(8'h35))}, 8'h00, 2'h3);
			run(oag_pkg::M_DPXIND, 8'hF0, 8'h00, {mb(dpa(8'h01)), mb(dpa(8'h00))}, 8'h00, 2'h1);
			run(oag_pkg::M_DPYIND, 8'hFF, 8'h00, {mb(dpa(8'h00)), mb(dpa(8'hFF))} + 16'h0055, 8'h00, 2'h1);
			run(oag_pkg::M_ABSIND, 8'h25, 8'hC0, {mb(16'hC026), mb(16'hC025)}, 8'h00, 2'h3);
		end
		$display("indirect modes done");
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		repeat (10) @(negedge clk_i);
		reset_n_i = 1'h1;
		t_direct();
		t_index();
		t_indirect();
		t_reset();
		stop_test();
	end
endmodule
